// file: verilog/gpio_strap_pkg.sv
package gpio_strap_pkg;

	localparam int GPIO_WIDTH          = 16;
	localparam int STRAP_WIDTH         = 13;
	localparam int SLAVE_ADDR_WIDTH    = 4;

	// Strap pin positions
	localparam int POS_SLAVE_ADDR_LO   = 0;
	localparam int POS_EEPROM_LOAD_DIS = 4;
	localparam int POS_EEPROM_ADDR_SEL = 5;
	localparam int POS_ADDR_MODE       = 6;
	localparam int POS_RX_SWAP         = 7;
	localparam int POS_TX_SWAP         = 8;
	localparam int POS_HOST_ROLE       = 9;
	localparam int POS_BASE_ID         = 10;
	localparam int POS_REFCLK_LO       = 11;

	// Fixed-function output pins and first software-driven pin
	localparam int POS_ECC_OUT         = 0;
	localparam int POS_LINK_DOWN_OUT   = 1;
	localparam int POS_IRQ_OUT         = 2;
	localparam int POS_SW_LO           = 3;

	// Stability window after reset release
	localparam int STRAP_HOLD_CYCLES   = 4000;
	localparam logic [11:0] HOLD_LAST  = 12'(STRAP_HOLD_CYCLES - 1);

	// EEPROM address upper bits and default low bits
	localparam logic [4:0] EEPROM_ADDR_HI = 5'h14;
	localparam logic [1:0] EEPROM_ADDR_LO_DEFAULT = 2'h0;

	// Slave address upper bits (neutral value)
	localparam logic [2:0] SLAVE_ADDR_HI_DEFAULT = 3'h5;

	// Reset values
	localparam logic [15:0] GPIO_DIR_RST  = 16'h0000;
	localparam logic [12:0] STRAP_RST     = 13'h0000;

	typedef enum logic [1:0] {
		REF_RESERVED = 2'h0,
		REF_156M25   = 2'h1,
		REF_100M     = 2'h2,
		REF_125M     = 2'h3
	} refclk_sel_t;

	typedef enum {
		ST_RESET,
		ST_WINDOW,
		ST_RUN
	} cap_state_t;

	// Fabric rate support mask: bit0 1.25, bit1 2.5, bit2 3.125, bit3 5 Gbaud
	function automatic logic [3:0] fabric_rates(input logic [1:0] sel);
		unique case (sel)
			REF_100M:             fabric_rates = 4'hb;
			REF_125M, REF_156M25: fabric_rates = 4'hf;
			default:              fabric_rates = 4'h0;
		endcase
	endfunction

endpackage

// file: verilog/strap_sync_if.sv
`timescale 1ns/100ps
interface strap_sync_if;
	logic [15:0] pin_raw;
	logic [15:0] pin_sync;
	modport sync_side (input pin_raw, output pin_sync);
	modport user_side (output pin_raw, input pin_sync);
endinterface

// file: verilog/pin_sync.sv
`timescale 1ns/100ps
module pin_sync
	import gpio_strap_pkg::*;
(
	input  wire logic          ref_clk,
	input  wire logic          rst,
	strap_sync_if.sync_side    sif
);
	logic [15:0] meta_ff;
	logic [15:0] sync_ff;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			meta_ff <= 16'h0000;
			sync_ff <= 16'h0000;
		end else begin
			meta_ff <= sif.pin_raw;
			sync_ff <= meta_ff;
		end
	end

	assign sif.pin_sync = sync_ff;
endmodule // pin_sync

// file: verilog/gpio_and_strap_capture.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Contract
// RULE_01: Each of 16 pins individually configurable as input or output.
// RULE_02: Pin 0 output is high while any unit reports uncorrectable ECC error.
// RULE_03: Pin 1 output is high while PCIe is not data-link-active.
// RULE_04: Pin 2 output is high while any interrupt source is active.
// RULE_05: Pins 3 to 15 as outputs drive software-programmed values.
// RULE_06: Outside party holds straps on pins 0-12 for 4000 cycles after reset.
// RULE_07: Strap levels ignored once reset processing completes.
// RULE_08: Straps decoded from fixed pin positions at reset.
// RULE_09: Clock mode strap high selects common clock, low non-common.
// RULE_10: Refclk strap 11=125, 10=100, 01=156.25 MHz, 00 reserved.
// RULE_11: 100 MHz excludes 3.125 Gbaud; PCIe 2.5 and 5 always supported. The code clears pcie_rate_mask when the refclk strap is 00 (reserved).
// RULE_12: Load disable strap 1 skips EEPROM boot load, 0 performs it.
// RULE_13: With loading on, address mode 0 one byte, 1 two bytes.
// RULE_14: With loading off, address mode picks root complex or I2C master.
// RULE_15: Slave address strap bits form low bits of own 7-bit address.
// RULE_16: EEPROM address built from slave strap bits and address select.
// RULE_17: Software may overwrite strapped slave address after reset.
// RULE_18: EEPROM address 10100 plus strap bits 1:0 or 00; overridable.
// RULE_19: Device reset returns all logic and captured straps to reset state.
// RULE_20: Straps latched at window end, held until next reset.
// RULE_21: Pins left undriven during reset and capture window.
module gpio_and_strap_capture
	import gpio_strap_pkg::*;
#(
	parameter int HOLD_CYCLES = STRAP_HOLD_CYCLES
)(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [15:0] gpio_in,
	output logic      [15:0] gpio_out,
	output logic      [15:0] gpio_oe,
	input  wire logic [15:0] gpio_dir,
	input  wire logic [15:0] gpio_sw_data,
	input  wire logic        clock_mode_strap,
	input  wire logic        ecc_err_block_dma_unit,
	input  wire logic        ecc_err_messaging_unit,
	input  wire logic        ecc_err_pcie_to_fabric_map_unit,
	input  wire logic        ecc_err_fabric_to_pcie_map_unit,
	input  wire logic        ecc_err_fabric_mac_nondata,
	input  wire logic        pcie_dl_active,
	input  wire logic        irq_active,
	input  wire logic        slave_addr_wr,
	input  wire logic [6:0]  slave_addr_wdata,
	input  wire logic        eeprom_addr_wr,
	input  wire logic [6:0]  eeprom_addr_wdata,
	output logic             straps_valid,
	output logic [3:0]       slave_addr_strap,
	output logic             eeprom_load_disable,
	output logic             eeprom_addr_sel,
	output logic             eeprom_addr_mode_strap,
	output logic             rx_lane_swap_strap,
	output logic             tx_lane_swap_strap,
	output logic             host_role_strap,
	output logic             base_id_strap,
	output logic [1:0]       refclk_freq_strap,
	output logic             refclk_reserved,
	output logic             pcie_common_clock,
	output logic [3:0]       fabric_rate_mask,
	output logic [1:0]       pcie_rate_mask,
	output logic             eeprom_boot_en,
	output logic             eeprom_two_byte_addr,
	output logic             boot_by_i2c_master,
	output logic             boot_by_root_complex,
	output logic [6:0]       i2c_slave_addr,
	output logic [6:0]       eeprom_dev_addr
);
	if (HOLD_CYCLES < 1 || HOLD_CYCLES > 4096) begin : g_hold_check
		$error("HOLD_CYCLES out of range");
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin synchroniser
	strap_sync_if sif ();
	assign sif.pin_raw = gpio_in;

	pin_sync u_sync (
		.ref_clk (ref_clk),
		.rst     (rst),
		.sif     (sif)
	);

	////////////////////////////////////////////////////////////////////////////
	// Clock mode strap synchroniser
	logic clock_mode_meta_ff;
	logic clock_mode_sync_ff;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			clock_mode_meta_ff <= 1'b0;
			clock_mode_sync_ff <= 1'b0;
		end else begin
			clock_mode_meta_ff <= clock_mode_strap;
			clock_mode_sync_ff <= clock_mode_meta_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Capture window sequencer
	cap_state_t  state_ff;
	logic [11:0] cnt_ff;
	localparam logic [11:0] LAST = 12'(HOLD_CYCLES - 1);

	always_ff @(posedge ref_clk) begin
		if (rst) begin // RULE_19
			state_ff <= ST_RESET;
			cnt_ff   <= 12'h000;
		end else begin
			unique case (state_ff)
				ST_RESET: begin
					state_ff <= ST_WINDOW;
					cnt_ff   <= 12'h000;
				end
				ST_WINDOW: begin
					if (cnt_ff == LAST) begin
						state_ff <= ST_RUN;
					end else begin
						cnt_ff <= cnt_ff + 12'h001;
					end
				end
				ST_RUN: begin
					state_ff <= ST_RUN; // RULE_07
				end
			endcase
		end
	end

	wire capture_now = (state_ff == ST_WINDOW) && (cnt_ff == LAST);

	////////////////////////////////////////////////////////////////////////////
	// Strap holding registers
	logic [12:0] strap_ff;
	logic        clock_mode_ff;
	logic        valid_ff;

	always_ff @(posedge ref_clk) begin
		if (rst) begin // RULE_19
			strap_ff      <= STRAP_RST;
			clock_mode_ff <= 1'b0;
			valid_ff      <= 1'b0;
		end else if (capture_now) begin // RULE_20
			strap_ff      <= sif.pin_sync[12:0]; // RULE_08
			clock_mode_ff <= clock_mode_sync_ff;
			valid_ff      <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Decoded strap outputs
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			straps_valid           <= 1'b0;
			slave_addr_strap       <= 4'h0;
			eeprom_load_disable    <= 1'b0;
			eeprom_addr_sel        <= 1'b0;
			eeprom_addr_mode_strap <= 1'b0;
			rx_lane_swap_strap     <= 1'b0;
			tx_lane_swap_strap     <= 1'b0;
			host_role_strap        <= 1'b0;
			base_id_strap          <= 1'b0;
			refclk_freq_strap      <= 2'h0;
			refclk_reserved        <= 1'b0;
			pcie_common_clock      <= 1'b0;
			fabric_rate_mask       <= 4'h0;
			pcie_rate_mask         <= 2'h0;
			eeprom_boot_en         <= 1'b0;
			eeprom_two_byte_addr   <= 1'b0;
			boot_by_i2c_master     <= 1'b0;
			boot_by_root_complex   <= 1'b0;
		end else begin
			straps_valid           <= valid_ff;
			slave_addr_strap       <= strap_ff[POS_SLAVE_ADDR_LO +: 4]; // RULE_08
			eeprom_load_disable    <= strap_ff[POS_EEPROM_LOAD_DIS];
			eeprom_addr_sel        <= strap_ff[POS_EEPROM_ADDR_SEL];
			eeprom_addr_mode_strap <= strap_ff[POS_ADDR_MODE];
			rx_lane_swap_strap     <= strap_ff[POS_RX_SWAP];
			tx_lane_swap_strap     <= strap_ff[POS_TX_SWAP];
			host_role_strap        <= strap_ff[POS_HOST_ROLE];
			base_id_strap          <= strap_ff[POS_BASE_ID];
			refclk_freq_strap      <= strap_ff[POS_REFCLK_LO +: 2];
			refclk_reserved        <= valid_ff &&
				(strap_ff[POS_REFCLK_LO +: 2] == REF_RESERVED); // RULE_10
			pcie_common_clock      <= clock_mode_ff; // RULE_09
			fabric_rate_mask       <= valid_ff ?
				fabric_rates(strap_ff[POS_REFCLK_LO +: 2]) : 4'h0; // RULE_11
			pcie_rate_mask         <= (valid_ff &&
				(strap_ff[POS_REFCLK_LO +: 2] != REF_RESERVED)) ? 2'h3 : 2'h0; // RULE_11
			eeprom_boot_en         <= valid_ff && !strap_ff[POS_EEPROM_LOAD_DIS]; // RULE_12
			eeprom_two_byte_addr   <= !strap_ff[POS_EEPROM_LOAD_DIS] &&
				strap_ff[POS_ADDR_MODE]; // RULE_13
			boot_by_i2c_master     <= valid_ff && strap_ff[POS_EEPROM_LOAD_DIS] &&
				strap_ff[POS_ADDR_MODE]; // RULE_14
			boot_by_root_complex   <= valid_ff && strap_ff[POS_EEPROM_LOAD_DIS] &&
				!strap_ff[POS_ADDR_MODE]; // RULE_14
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// I2C addresses with software override
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			i2c_slave_addr <= 7'h00;
		end else if (valid_ff && slave_addr_wr) begin
			i2c_slave_addr <= slave_addr_wdata; // RULE_17
		end else if (capture_now) begin
			i2c_slave_addr <= {SLAVE_ADDR_HI_DEFAULT, sif.pin_sync[3:0]}; // RULE_15
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			eeprom_dev_addr <= 7'h00;
		end else if (valid_ff && eeprom_addr_wr) begin
			eeprom_dev_addr <= eeprom_addr_wdata; // RULE_18
		end else if (capture_now) begin
			eeprom_dev_addr <= {EEPROM_ADDR_HI, sif.pin_sync[POS_EEPROM_ADDR_SEL] ?
				sif.pin_sync[1:0] : EEPROM_ADDR_LO_DEFAULT}; // RULE_16 RULE_18
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// GPIO output drive
	logic [15:0] nxt_gpio_out;
	always_comb begin
		nxt_gpio_out = gpio_sw_data; // RULE_05
		nxt_gpio_out[POS_ECC_OUT] = ecc_err_block_dma_unit | ecc_err_messaging_unit |
			ecc_err_pcie_to_fabric_map_unit | ecc_err_fabric_to_pcie_map_unit |
			ecc_err_fabric_mac_nondata; // RULE_02
		nxt_gpio_out[POS_LINK_DOWN_OUT] = !pcie_dl_active; // RULE_03
		nxt_gpio_out[POS_IRQ_OUT] = irq_active; // RULE_04
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			gpio_out <= 16'h0000;
			gpio_oe  <= GPIO_DIR_RST;
		end else begin
			gpio_out <= nxt_gpio_out;
			gpio_oe  <= valid_ff ? gpio_dir : GPIO_DIR_RST; // RULE_01 RULE_21
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions on pin drive
	logic ecc_any_err;
	assign ecc_any_err = ecc_err_block_dma_unit | ecc_err_messaging_unit |
		ecc_err_pcie_to_fabric_map_unit | ecc_err_fabric_to_pcie_map_unit |
		ecc_err_fabric_mac_nondata;

	a_window_no_drive: assert property ( // RULE_21
		@(posedge ref_clk) disable iff (rst) !valid_ff |=> gpio_oe == 16'h0000)
		else $error("pin driven in window");
	a_dir_follows: assert property ( // RULE_01
		@(posedge ref_clk) disable iff (rst) valid_ff |=> gpio_oe == $past(gpio_dir))
		else $error("oe not from dir");
	a_ecc_pin: assert property ( // RULE_02
		@(posedge ref_clk) disable iff (rst) ecc_err_messaging_unit |=> gpio_out[0])
		else $error("ecc pin low");
	a_ecc_any: assert property ( // RULE_02
		@(posedge ref_clk) disable iff (rst) ecc_any_err |=> gpio_out[POS_ECC_OUT])
		else $error("ecc pin low on any unit");
	a_ecc_clear: assert property ( // RULE_02
		@(posedge ref_clk) disable iff (rst) !ecc_any_err |=> !gpio_out[POS_ECC_OUT])
		else $error("ecc pin high without error");
	a_link_pin: assert property ( // RULE_03
		@(posedge ref_clk) disable iff (rst) 1'b1 |=> gpio_out[1] == !$past(pcie_dl_active))
		else $error("link pin wrong");
	a_irq_pin: assert property ( // RULE_04
		@(posedge ref_clk) disable iff (rst) 1'b1 |=> gpio_out[2] == $past(irq_active))
		else $error("irq pin wrong");
	a_sw_pins: assert property ( // RULE_05
		@(posedge ref_clk) disable iff (rst) 1'b1 |=> gpio_out[15:3] == $past(gpio_sw_data[15:3]))
		else $error("sw pins");

	// Assertions on the capture sequence
	a_reset_quiet: assert property ( // RULE_19
		@(posedge ref_clk) rst |=> gpio_oe == 16'h0000 && !straps_valid && !valid_ff)
		else $error("reset left state");
	a_reset_release: assert property ( // RULE_19
		@(posedge ref_clk) disable iff (rst) $fell(rst) |-> state_ff == ST_RESET && cnt_ff == 12'h000)
		else $error("sequencer not reset");
	a_window_count: assert property ( // RULE_20
		@(posedge ref_clk) disable iff (rst) state_ff == ST_WINDOW && cnt_ff != LAST
		|=> cnt_ff == $past(cnt_ff) + 12'h001) else $error("window count skipped");
	a_capture_time: assert property ( // RULE_20
		@(posedge ref_clk) disable iff (rst) $rose(valid_ff) |-> cnt_ff == LAST)
		else $error("capture time");
	a_capture_once: assert property ( // RULE_07
		@(posedge ref_clk) disable iff (rst) capture_now |=> !capture_now)
		else $error("second capture");
	a_valid_sticky: assert property ( // RULE_20
		@(posedge ref_clk) disable iff (rst) valid_ff |=> valid_ff)
		else $error("valid dropped");
	a_run_hold: assert property ( // RULE_07
		@(posedge ref_clk) disable iff (rst) state_ff == ST_RUN |=> state_ff == ST_RUN)
		else $error("left run state");
	a_straps_frozen: assert property ( // RULE_07
		@(posedge ref_clk) disable iff (rst) valid_ff && $past(valid_ff) |-> $stable(strap_ff))
		else $error("strap moved");
	a_outputs_frozen: assert property ( // RULE_07
		@(posedge ref_clk) disable iff (rst) straps_valid && $past(straps_valid) |->
		$stable(slave_addr_strap) && $stable(refclk_freq_strap) && $stable(pcie_common_clock))
		else $error("strap output moved");

	// Assertions on decoded straps
	a_strap_fields: assert property ( // RULE_08
		@(posedge ref_clk) disable iff (rst) valid_ff |=>
		slave_addr_strap == strap_ff[POS_SLAVE_ADDR_LO +: 4] &&
		host_role_strap == strap_ff[POS_HOST_ROLE] && base_id_strap == strap_ff[POS_BASE_ID])
		else $error("strap field wrong");
	a_clock_mode: assert property ( // RULE_09
		@(posedge ref_clk) disable iff (rst) valid_ff |=> pcie_common_clock == clock_mode_ff)
		else $error("clock mode wrong");
	a_refclk_reserved: assert property ( // RULE_10
		@(posedge ref_clk) disable iff (rst)
		valid_ff && strap_ff[POS_REFCLK_LO +: 2] == REF_RESERVED |=> refclk_reserved)
		else $error("reserved refclk missed");
	a_rate_100: assert property ( // RULE_11
		@(posedge ref_clk) disable iff (rst)
		valid_ff && strap_ff[POS_REFCLK_LO +: 2] == REF_100M |=> fabric_rate_mask == 4'hb)
		else $error("fabric rates at 100 MHz");
	a_rate_pcie: assert property ( // RULE_11
		@(posedge ref_clk) disable iff (rst)
		valid_ff && strap_ff[POS_REFCLK_LO +: 2] != REF_RESERVED |=> pcie_rate_mask == 2'h3)
		else $error("pcie rates");
	a_boot_load: assert property ( // RULE_12
		@(posedge ref_clk) disable iff (rst)
		valid_ff |=> eeprom_boot_en == !strap_ff[POS_EEPROM_LOAD_DIS])
		else $error("boot load enable");
	a_boot_excl: assert property ( // RULE_12
		@(posedge ref_clk) disable iff (rst)
		!(eeprom_boot_en && (boot_by_i2c_master || boot_by_root_complex)))
		else $error("boot modes overlap");
	a_two_byte: assert property ( // RULE_13
		@(posedge ref_clk) disable iff (rst) valid_ff && !strap_ff[POS_EEPROM_LOAD_DIS]
		|=> eeprom_two_byte_addr == strap_ff[POS_ADDR_MODE]) else $error("address bytes");
	a_boot_pick: assert property ( // RULE_14
		@(posedge ref_clk) disable iff (rst) valid_ff && strap_ff[POS_EEPROM_LOAD_DIS] |=>
		boot_by_i2c_master == strap_ff[POS_ADDR_MODE] &&
		boot_by_root_complex == !strap_ff[POS_ADDR_MODE]) else $error("boot loader pick");

	// Assertions on addresses
	a_slave_capture: assert property ( // RULE_15
		@(posedge ref_clk) disable iff (rst) capture_now |=>
		i2c_slave_addr == {SLAVE_ADDR_HI_DEFAULT, strap_ff[POS_SLAVE_ADDR_LO +: 4]})
		else $error("slave addr capture");
	a_eeprom_lo: assert property ( // RULE_16
		@(posedge ref_clk) disable iff (rst) capture_now |=> eeprom_dev_addr[1:0] ==
		(strap_ff[POS_EEPROM_ADDR_SEL] ? strap_ff[1:0] : EEPROM_ADDR_LO_DEFAULT))
		else $error("eeprom low bits");
	a_eeprom_hi: assert property ( // RULE_18
		@(posedge ref_clk) disable iff (rst) capture_now |=> eeprom_dev_addr[6:2] == EEPROM_ADDR_HI)
		else $error("eeprom hi");
	a_slave_wr: assert property ( // RULE_17
		@(posedge ref_clk) disable iff (rst)
		valid_ff && slave_addr_wr |=> i2c_slave_addr == $past(slave_addr_wdata))
		else $error("slave write lost");
	a_slave_refused: assert property ( // RULE_17
		@(posedge ref_clk) disable iff (rst) !valid_ff && !capture_now |=> $stable(i2c_slave_addr))
		else $error("slave addr moved early");
	a_eeprom_wr: assert property ( // RULE_18
		@(posedge ref_clk) disable iff (rst)
		valid_ff && eeprom_addr_wr |=> eeprom_dev_addr == $past(eeprom_addr_wdata))
		else $error("eeprom write lost");
	a_eeprom_refused: assert property ( // RULE_18
		@(posedge ref_clk) disable iff (rst) !valid_ff && !capture_now |=> $stable(eeprom_dev_addr))
		else $error("eeprom addr moved early");

endmodule // gpio_and_strap_capture

// file: dv/strap_board.sv
`timescale 1ns/100ps
module strap_board (
	input  wire logic [15:0] board_level,
	input  wire logic [15:0] gpio_out,
	input  wire logic [15:0] gpio_oe,
	output logic      [15:0] pin_level
);
	// Strap resistors set the level wherever the device does not drive
	assign pin_level = (gpio_oe & gpio_out) | (~gpio_oe & board_level);
endmodule // strap_board

// file: dv/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	import gpio_strap_pkg::*;
	localparam int HOLD = 8;
	typedef struct packed {
		logic [13:0] strap;
		logic [3:0]  fab;
		logic [6:0]  eep;
	} row_t;
	logic        ref_clk, rst, cm, dl, irq, sa_wr, ea_wr, straps_valid;
	logic [4:0]  ecc;
	logic [6:0]  sa_wd, ea_wd, i2c_slave_addr, eeprom_dev_addr;
	logic [15:0] pins, board, gpio_out, gpio_oe, gpio_dir, sw;
	logic [3:0]  slave_addr_strap, fabric_rate_mask;
	logic [1:0]  refclk_freq_strap, pcie_rate_mask;
	logic        eeprom_load_disable, eeprom_addr_sel, eeprom_addr_mode_strap, rx_lane_swap_strap;
	logic        tx_lane_swap_strap, host_role_strap, base_id_strap, refclk_reserved;
	logic        pcie_common_clock, eeprom_boot_en, eeprom_two_byte_addr;
	logic        boot_by_i2c_master, boot_by_root_complex;
	int          bad_count, comparisons, n;
	row_t        rows [4] = '{'{14'h3d26, 4'hf, 7'h52}, '{14'h12c9, 4'hb, 7'h50},
	                          '{14'h2833, 4'hf, 7'h53}, '{14'h025f, 4'h0, 7'h50}};
	////////////////////////////////////////////////////////////////////////////////
	gpio_and_strap_capture #(.HOLD_CYCLES(HOLD)) i_gpio_and_strap_capture (
		.ref_clk(ref_clk), .rst(rst), .gpio_in(pins), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
		.gpio_dir(gpio_dir), .gpio_sw_data(sw), .clock_mode_strap(cm),
		.ecc_err_block_dma_unit(ecc[0]), .ecc_err_messaging_unit(ecc[1]),
		.ecc_err_pcie_to_fabric_map_unit(ecc[2]), .ecc_err_fabric_to_pcie_map_unit(ecc[3]),
		.ecc_err_fabric_mac_nondata(ecc[4]), .pcie_dl_active(dl), .irq_active(irq),
		.slave_addr_wr(sa_wr), .slave_addr_wdata(sa_wd), .eeprom_addr_wr(ea_wr),
		.eeprom_addr_wdata(ea_wd), .straps_valid(straps_valid),
		.slave_addr_strap(slave_addr_strap), .eeprom_load_disable(eeprom_load_disable),
		.eeprom_addr_sel(eeprom_addr_sel), .eeprom_addr_mode_strap(eeprom_addr_mode_strap),
		.rx_lane_swap_strap(rx_lane_swap_strap), .tx_lane_swap_strap(tx_lane_swap_strap),
		.host_role_strap(host_role_strap), .base_id_strap(base_id_strap),
		.refclk_freq_strap(refclk_freq_strap), .refclk_reserved(refclk_reserved),
		.pcie_common_clock(pcie_common_clock), .fabric_rate_mask(fabric_rate_mask),
		.pcie_rate_mask(pcie_rate_mask), .eeprom_boot_en(eeprom_boot_en),
		.eeprom_two_byte_addr(eeprom_two_byte_addr), .boot_by_i2c_master(boot_by_i2c_master),
		.boot_by_root_complex(boot_by_root_complex), .i2c_slave_addr(i2c_slave_addr),
		.eeprom_dev_addr(eeprom_dev_addr));
	strap_board i_strap_board (.board_level(board), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
		.pin_level(pins));
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL %0t %s", $time, msg);
		end
	endtask
	task automatic test_done();
		if (bad_count == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge ref_clk);
	endtask
	task automatic run_row(input row_t r);
		logic [12:0] s;
		s = r.strap[12:0];
		gpio_dir = 16'hffff;
		board = {3'h0, s};
		cm = r.strap[13];
		rst = 1'b1;
		cyc(8);
		rst = 1'b0;
		n = 0;
		while (straps_valid !== 1'b1 && n < 20) begin
			sa_wr = (n == 3);
			cyc(1);
			n++;
			chk(gpio_oe, (straps_valid === 1'b1) ? gpio_dir : 16'h0000, "pins driven in window");
		end
		sa_wr = 1'b0;
		chk(n, HOLD + 2, "capture moment");
		chk({refclk_freq_strap, base_id_strap, host_role_strap, tx_lane_swap_strap,
			rx_lane_swap_strap, eeprom_addr_mode_strap, eeprom_addr_sel, eeprom_load_disable,
			slave_addr_strap}, s, "strap fields");
		chk({pcie_common_clock, refclk_reserved}, {r.strap[13], s[12:11] == 2'h0},
			"clock mode");
		chk(fabric_rate_mask, r.fab, "fabric rates");
		chk(pcie_rate_mask, (s[12:11] != 2'h0) ? 2'h3 : 2'h0, "pcie rates");
		chk({eeprom_boot_en, eeprom_two_byte_addr, boot_by_i2c_master, boot_by_root_complex},
			{!s[4], !s[4] && s[6], s[4] && s[6], s[4] && !s[6]}, "boot");
		chk(i2c_slave_addr, {SLAVE_ADDR_HI_DEFAULT, s[3:0]}, "slave addr");
		chk(eeprom_dev_addr, r.eep, "eeprom addr");
		{board, cm, gpio_dir} = {~board, ~cm, 16'h0000};
		cyc(4);
		chk({refclk_freq_strap, base_id_strap, host_role_strap, tx_lane_swap_strap,
			rx_lane_swap_strap, eeprom_addr_mode_strap, eeprom_addr_sel, eeprom_load_disable,
			slave_addr_strap, pcie_common_clock, i2c_slave_addr},
			{s, r.strap[13], SLAVE_ADDR_HI_DEFAULT, s[3:0]}, "late pins");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#200000;
		bad_count++;
		test_done();
	end
	initial begin
		bad_count = 0;
		comparisons = 0;
		{rst, cm, dl, irq, sa_wr, ea_wr, ecc} = {1'b1, 11'h000};
		{sa_wd, ea_wd, board, sw} = {7'h2b, 7'h11, 16'h0000, 16'h0000};
		gpio_dir = 16'hffff;
		foreach (rows[i]) run_row(rows[i]);
		gpio_dir = 16'ha5c3;
		cyc(2);
		chk(gpio_oe, 16'ha5c3, "direction");
		{gpio_dir, sw, dl} = {16'hffff, 16'hbeef, 1'b1};
		cyc(2);
		chk(gpio_out, {sw[15:3], 3'b000}, "sw data");
		for (int i = 0; i < 5; i++) begin
			ecc = 5'h01 << i;
			cyc(2);
			chk(gpio_out[2:0], 3'b001, "ecc pin");
		end
		{ecc, dl, irq} = {5'h00, 1'b0, 1'b1};
		cyc(2);
		chk(gpio_out[2:0], 3'b110, "link and irq pins");
		sa_wr = 1'b1;
		ea_wr = 1'b1;
		cyc(1);
		{sa_wr, ea_wd} = {1'b0, 7'h22};
		cyc(1);
		ea_wr = 1'b0;
		cyc(2);
		chk(i2c_slave_addr, 7'h2b, "slave override");
		chk(eeprom_dev_addr, 7'h22, "eeprom override");
		rst = 1'b1;
		cyc(2);
		chk({straps_valid, gpio_oe, i2c_slave_addr, eeprom_dev_addr}, 31'h0, "reset");
		chk({gpio_out, fabric_rate_mask, pcie_rate_mask, refclk_freq_strap, eeprom_boot_en,
			pcie_common_clock}, 26'h0, "reset outputs");
		test_done();
	end
endmodule // tb_top
